// ---- rtl/relay_pid_autotuner.sv ----
// relay auto-tuning engine for one PID loop, Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module relay_pid_autotuner #(
  parameter int unsigned STEP_CYCLES = atune_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // process side
  input wire logic [15:0] PV_IN,
  output logic [15:0] MV_OUT,
  output logic [31:0] PWM_OUT,
  output logic ERR_OUT
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [15:0] pv_meta_r, pv_r;
  logic ack_r, bus_req, wr, start_p, stop_p;
  logic [31:0] rd_nxt;
  logic [15:0] sv_r, cycle_r, mvmax_r, mvmin_r, prd_r, hys_r;
  logic [4:0] pwmpt_r;
  logic rev_r, pwmen_r, relay_hi_r, err_r, above, below, sw_dn, op_tick, step;
  logic [1:0] mode_r;
  logic [7:0] code_r;
  atune_pkg::state_t state_r;
  logic [15:0] step_cnt_r, op_cnt_r, per_cnt_r, width_r, mv_r, pwm_cnt_r;
  logic signed [17:0] pv_s, upper, lower;
  logic signed [15:0] pmax_r, pmin_r;
  logic [3:0] swing_cnt_r;
  logic [31:0] pu_r, ku_r, kp_r, ti_r, td_r;
  logic [15:0] dmv, mv_ofs;
  logic div_done;
  logic [32:0] quo;
  logic [48:0] kp_prod, ti_prod;
  logic [16:0] gain;
  logic pwm_on_r;

  // reset released through two flops
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // process value synchroniser; only pv_r is read by logic
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pv_meta_r <= 16'h0000;
      pv_r <= 16'h0000;
    end else begin
      pv_meta_r <= PV_IN;
      pv_r <= pv_meta_r;
    end
  end

  // byte-lane merge for the sixteen-bit settings
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] m;
    m = old;
    if (sel[0]) m[7:0] = d[7:0];
    if (sel[1]) m[15:8] = d[15:8];
    return m;
  endfunction

  // one ack per request, the cycle after it is seen
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr = bus_req & WB_WE_I;
  assign start_p = wr && WB_ADR_I == atune_pkg::OFS_CTRL && WB_SEL_I[0]
                   && WB_DAT_I[atune_pkg::CTRL_START];
  assign stop_p = wr && WB_ADR_I == atune_pkg::OFS_CTRL && WB_SEL_I[0]
                  && WB_DAT_I[atune_pkg::CTRL_STOP];
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) ack_r <= 1'b0;
    else ack_r <= bus_req;
  end
  assign WB_ACK_O = ack_r;

  // settings written by software
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sv_r <= atune_pkg::RST_SV;
      cycle_r <= atune_pkg::RST_CYCLE;
      mvmax_r <= atune_pkg::RST_MV_MAX;
      mvmin_r <= atune_pkg::RST_MV_MIN;
      prd_r <= atune_pkg::RST_PWM_PRD;
      hys_r <= atune_pkg::RST_HYS;
      pwmpt_r <= 5'h00;
      rev_r <= 1'b0;
      pwmen_r <= 1'b0;
      mode_r <= atune_pkg::MODE_PID;
    end else if (wr) begin
      unique case (WB_ADR_I)
        atune_pkg::OFS_CTRL: begin
          if (WB_SEL_I[0]) begin
            rev_r <= WB_DAT_I[atune_pkg::CTRL_REV];
            pwmen_r <= WB_DAT_I[atune_pkg::CTRL_PWM_EN];
            mode_r <= WB_DAT_I[atune_pkg::CTRL_MODE +: 2];
          end
        end
        atune_pkg::OFS_SV: sv_r <= merge16(sv_r, WB_DAT_I, WB_SEL_I);
        atune_pkg::OFS_CYCLE: cycle_r <= merge16(cycle_r, WB_DAT_I, WB_SEL_I);
        atune_pkg::OFS_MV_MAX: mvmax_r <= merge16(mvmax_r, WB_DAT_I, WB_SEL_I);
        atune_pkg::OFS_MV_MIN: mvmin_r <= merge16(mvmin_r, WB_DAT_I, WB_SEL_I);
        atune_pkg::OFS_PWM_PT: if (WB_SEL_I[0]) pwmpt_r <= WB_DAT_I[4:0];
        atune_pkg::OFS_PWM_PRD: prd_r <= merge16(prd_r, WB_DAT_I, WB_SEL_I);
        atune_pkg::OFS_HYS: hys_r <= merge16(hys_r, WB_DAT_I, WB_SEL_I);
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    unique case (WB_ADR_I)
      atune_pkg::OFS_CTRL: rd_nxt = {26'h0, mode_r, pwmen_r, rev_r, 2'h0};
      atune_pkg::OFS_SV: rd_nxt = {16'h0000, sv_r};
      atune_pkg::OFS_CYCLE: rd_nxt = {16'h0000, cycle_r};
      atune_pkg::OFS_MV_MAX: rd_nxt = {16'h0000, mvmax_r};
      atune_pkg::OFS_MV_MIN: rd_nxt = {16'h0000, mvmin_r};
      atune_pkg::OFS_PWM_PT: rd_nxt = {27'h0, pwmpt_r};
      atune_pkg::OFS_PWM_PRD: rd_nxt = {16'h0000, prd_r};
      atune_pkg::OFS_HYS: rd_nxt = {16'h0000, hys_r};
      atune_pkg::OFS_STATUS: rd_nxt = {16'h0000, code_r, 4'h0, relay_hi_r, err_r,
                                       state_r == atune_pkg::ST_DONE,
                                       state_r inside {atune_pkg::ST_RELAY,
                                                       atune_pkg::ST_DIV,
                                                       atune_pkg::ST_COEF}};
      atune_pkg::OFS_PV: rd_nxt = {16'h0000, pv_r};
      atune_pkg::OFS_MV: rd_nxt = {16'h0000, mv_r};
      atune_pkg::OFS_ULT_GAIN: rd_nxt = ku_r;
      atune_pkg::OFS_ULT_PERIOD: rd_nxt = pu_r;
      atune_pkg::OFS_KP: rd_nxt = kp_r;
      atune_pkg::OFS_TI: rd_nxt = ti_r;
      atune_pkg::OFS_TD: rd_nxt = td_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) WB_DAT_O <= 32'h00000000;
    else if (bus_req) WB_DAT_O <= rd_nxt;
  end

  // 0.1 ms step and operation cycle ticks
  // one evaluation per cycle
  assign step = (step_cnt_r == 16'(STEP_CYCLES - 1));
  assign op_tick = step && state_r == atune_pkg::ST_RELAY && (op_cnt_r >= cycle_r - 16'h0001);
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 16'h0000;
      op_cnt_r <= 16'h0000;
    end else begin
      step_cnt_r <= step ? 16'h0000 : step_cnt_r + 16'h0001;
      if (state_r != atune_pkg::ST_RELAY || op_tick) op_cnt_r <= 16'h0000;
      else if (step) op_cnt_r <= op_cnt_r + 16'h0001;
    end
  end

  // signed thresholds around the set value
  // hysteresis band
  assign pv_s = 18'(signed'(pv_r));
  assign upper = 18'(signed'(sv_r)) + signed'({2'b00, hys_r});
  assign lower = 18'(signed'(sv_r)) - signed'({2'b00, hys_r});
  assign above = pv_s > upper;
  assign below = pv_s < lower;
  // reverse swaps which crossing ends the high phase
  assign sw_dn = op_tick && state_r == atune_pkg::ST_RELAY && relay_hi_r
                 && (rev_r ? below : above);
  assign dmv = 16'(signed'(mvmax_r) - signed'(mvmin_r));

  // relay output phase
  // start high, toggle at threshold crossings
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) relay_hi_r <= 1'b0;
    else if (start_p) relay_hi_r <= 1'b1;
    else if (sw_dn) relay_hi_r <= 1'b0;
    else if (op_tick && state_r == atune_pkg::ST_RELAY && !relay_hi_r
             && (rev_r ? above : below)) relay_hi_r <= 1'b1;
  end

  // swing peaks and period between falling switchings
  // width and period of the oscillation
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pmax_r <= 16'h0000;
      pmin_r <= 16'h0000;
      per_cnt_r <= 16'h0000;
      swing_cnt_r <= 4'h0;
      width_r <= 16'h0000;
      pu_r <= 32'h00000000;
    end else if (start_p) begin
      swing_cnt_r <= 4'h0;
      per_cnt_r <= 16'h0000;
    end else if (sw_dn) begin
      pmax_r <= signed'(pv_r);
      pmin_r <= signed'(pv_r);
      per_cnt_r <= 16'h0000;
      swing_cnt_r <= swing_cnt_r + 4'h1;
      width_r <= 16'(pmax_r - pmin_r);
      pu_r <= 32'(per_cnt_r + 16'h0001) * 32'(cycle_r);
    end else if (op_tick && state_r == atune_pkg::ST_RELAY) begin
      if (signed'(pv_r) > pmax_r) pmax_r <= signed'(pv_r);
      if (signed'(pv_r) < pmin_r) pmin_r <= signed'(pv_r);
      if (per_cnt_r != 16'hFFFF) per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  // ultimate gain divider, Q16; latched width, the live peaks restart here
  // four over pi times span, over width
  atune_div u_div (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .start(state_r == atune_pkg::ST_RELAY && sw_dn && pmax_r != pmin_r
           && swing_cnt_r == atune_pkg::SETTLE_CYCLES),
    .dividend(33'(dmv) * 33'(atune_pkg::FOUR_OVER_PI)),
    .divisor(width_r),
    .done(div_done),
    .quotient(quo)
  );

  // tuning sequence and fault handling
  // fault entry and error code
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= atune_pkg::ST_IDLE;
      err_r <= 1'b0;
      code_r <= atune_pkg::ERR_NONE;
    end else if (start_p) begin
      err_r <= 1'b0;
      code_r <= atune_pkg::ERR_NONE;
      state_r <= atune_pkg::ST_RELAY;
      if (signed'(mvmax_r) < signed'(mvmin_r)) begin
        state_r <= atune_pkg::ST_FAULT;
        err_r <= 1'b1;
        code_r <= atune_pkg::ERR_MV_ORDER;
      end else if (cycle_r < atune_pkg::CYCLE_MIN) begin
        state_r <= atune_pkg::ST_FAULT;
        err_r <= 1'b1;
        code_r <= atune_pkg::ERR_CYCLE;
      end else if (WB_DAT_I[atune_pkg::CTRL_PWM_EN] && prd_r < atune_pkg::CYCLE_MIN) begin
        state_r <= atune_pkg::ST_FAULT;
        err_r <= 1'b1;
        code_r <= atune_pkg::ERR_PWM_PRD;
      end
    end else if (stop_p) begin
      state_r <= atune_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        atune_pkg::ST_RELAY: begin
          if (sw_dn && swing_cnt_r == atune_pkg::SETTLE_CYCLES) begin
            if (pmax_r == pmin_r) begin
              state_r <= atune_pkg::ST_FAULT;
              err_r <= 1'b1;
              code_r <= atune_pkg::ERR_NO_SWING;
            end else begin
              state_r <= atune_pkg::ST_DIV;
            end
          end
        end
        atune_pkg::ST_DIV: if (div_done) state_r <= atune_pkg::ST_COEF;
        atune_pkg::ST_COEF: state_r <= atune_pkg::ST_DONE;
        atune_pkg::ST_IDLE, atune_pkg::ST_DONE, atune_pkg::ST_FAULT: ;
      endcase
    end
  end
  assign ERR_OUT = err_r;

  // coefficient products in Q16
  // Ziegler-Nichols table
  assign gain = mode_r == atune_pkg::MODE_P ? atune_pkg::GAIN_P :
                mode_r == atune_pkg::MODE_PI ? atune_pkg::GAIN_PI : atune_pkg::GAIN_PID;
  assign kp_prod = 49'(ku_r) * 49'(gain);
  assign ti_prod = 49'(pu_r) * 49'(atune_pkg::INV_1P2);
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ku_r <= 32'h00000000;
      kp_r <= 32'h00000000;
      ti_r <= 32'h00000000;
      td_r <= 32'h00000000;
    end else if (div_done) begin
      ku_r <= quo[32] ? 32'hFFFFFFFF : quo[31:0];
    end else if (state_r == atune_pkg::ST_COEF) begin
      kp_r <= kp_prod[47:16];
      ti_r <= mode_r == atune_pkg::MODE_PI ? ti_prod[47:16] :
              mode_r == atune_pkg::MODE_PID ? {1'b0, pu_r[31:1]} : 32'h00000000;
      td_r <= mode_r == atune_pkg::MODE_PID ? {3'h0, pu_r[31:3]} : 32'h00000000;
    end
  end

  // manipulated value; minimum whenever not relaying
  // minimum output on fault
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) mv_r <= 16'h0000;
    else if (state_r == atune_pkg::ST_RELAY && relay_hi_r) mv_r <= mvmax_r;
    else mv_r <= mvmin_r;
  end
  assign MV_OUT = mv_r;

  // pulse-width duty: cnt*span < (mv-min)*period, no divider needed
  // period in steps, linear duty
  assign mv_ofs = 16'(signed'(mv_r) - signed'(mvmin_r));
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_r <= 16'h0000;
      pwm_on_r <= 1'b0;
    end else begin
      if (!pwmen_r) pwm_cnt_r <= 16'h0000;
      else if (step) pwm_cnt_r <= pwm_cnt_r + 16'h0001 >= prd_r ? 16'h0000
                                  : pwm_cnt_r + 16'h0001;
      pwm_on_r <= pwmen_r && dmv != 16'h0000
                  && 32'(pwm_cnt_r) * 32'(dmv) < 32'(mv_ofs) * 32'(prd_r);
    end
  end

  // one flop per output point
  // only the chosen point, only while enabled
  for (genvar i = 0; i < 32; i++) begin : g_pt
    always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) PWM_OUT[i] <= 1'b0;
      else PWM_OUT[i] <= pwm_on_r && pwmen_r && pwmpt_r == 5'(i);
    end
  end

  // checks
  start_high_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    start_p && signed'(mvmax_r) >= signed'(mvmin_r) && cycle_r >= atune_pkg::CYCLE_MIN &&
    !(WB_DAT_I[atune_pkg::CTRL_PWM_EN] && prd_r < atune_pkg::CYCLE_MIN) |=> ##1 mv_r == mvmax_r)
    else $error("tuning did not start at maximum output");
  hys_switch_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    op_tick && state_r == atune_pkg::ST_RELAY && relay_hi_r && !rev_r && above && !start_p
    |=> !relay_hi_r)
    else $error("relay did not drop above upper threshold");
  rev_switch_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    op_tick && state_r == atune_pkg::ST_RELAY && !relay_hi_r && rev_r && above && !start_p
    |=> relay_hi_r)
    else $error("reverse relay did not rise above upper threshold");
  order_err_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    start_p && signed'(mvmax_r) < signed'(mvmin_r)
    |=> state_r == atune_pkg::ST_FAULT && code_r == atune_pkg::ERR_MV_ORDER)
    else $error("limit order fault missed");
  fault_min_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    state_r == atune_pkg::ST_FAULT && !start_p |=> mv_r == $past(mvmin_r) && ERR_OUT)
    else $error("fault did not hold minimum output");
  run_clear_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    state_r == atune_pkg::ST_RELAY |-> !err_r && code_r == atune_pkg::ERR_NONE)
    else $error("error shown while tuning");
  pwm_off_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    !pwmen_r [*2] |=> PWM_OUT == 32'h00000000)
    else $error("pulse output while disabled");
  td_coef_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    state_r == atune_pkg::ST_COEF && mode_r == atune_pkg::MODE_PID
    |=> td_r == $past(pu_r) >> 3 && ti_r == $past(pu_r) >> 1)
    else $error("derivative or integral time wrong");
  op_rate_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    op_tick |=> !op_tick [*8])
    else $error("operation cycles too close");
  ack_pulse_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");
  done_c: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    state_r == atune_pkg::ST_COEF ##1 state_r == atune_pkg::ST_DONE);
  fault_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) $rose(err_r));
  pwm_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) $rose(|PWM_OUT));
endmodule
`default_nettype wire

// ---- rtl/atune_pkg.sv ----
// constants, register map and state type for the relay auto-tuner
package atune_pkg;
  // timing: one setting step is 0.1 ms
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_NS = 100000;
  localparam int unsigned STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam logic [15:0] CYCLE_MIN = 16'h0064;
  localparam logic [3:0] SETTLE_CYCLES = 4'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SV = 8'h04;
  localparam logic [7:0] OFS_CYCLE = 8'h08;
  localparam logic [7:0] OFS_MV_MAX = 8'h0C;
  localparam logic [7:0] OFS_MV_MIN = 8'h10;
  localparam logic [7:0] OFS_PWM_PT = 8'h14;
  localparam logic [7:0] OFS_PWM_PRD = 8'h18;
  localparam logic [7:0] OFS_HYS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PV = 8'h24;
  localparam logic [7:0] OFS_MV = 8'h28;
  localparam logic [7:0] OFS_ULT_GAIN = 8'h2C;
  localparam logic [7:0] OFS_ULT_PERIOD = 8'h30;
  localparam logic [7:0] OFS_KP = 8'h34;
  localparam logic [7:0] OFS_TI = 8'h38;
  localparam logic [7:0] OFS_TD = 8'h3C;
  // control word fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_REV = 2;
  localparam int unsigned CTRL_PWM_EN = 3;
  localparam int unsigned CTRL_MODE = 4;
  localparam logic [1:0] MODE_P = 2'h0;
  localparam logic [1:0] MODE_PI = 2'h1;
  localparam logic [1:0] MODE_PID = 2'h2;
  // status word fields
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_ERR = 2;
  localparam int unsigned STAT_RELAY = 3;
  localparam int unsigned STAT_CODE = 8;
  // reset values
  localparam logic [15:0] RST_SV = 16'h0000;
  localparam logic [15:0] RST_CYCLE = 16'h0064;
  localparam logic [15:0] RST_MV_MAX = 16'h0FA0;
  localparam logic [15:0] RST_MV_MIN = 16'h0000;
  localparam logic [15:0] RST_PWM_PRD = 16'h0000;
  localparam logic [15:0] RST_HYS = 16'h0000;
  // Q16 scale factors
  localparam logic [16:0] FOUR_OVER_PI = 17'h145F3;
  localparam logic [16:0] GAIN_P = 17'h08000;
  localparam logic [16:0] GAIN_PI = 17'h07333;
  localparam logic [16:0] GAIN_PID = 17'h0999A;
  localparam logic [16:0] INV_1P2 = 17'h0D555;
  // error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_MV_ORDER = 8'h01;
  localparam logic [7:0] ERR_NO_SWING = 8'h02;
  localparam logic [7:0] ERR_CYCLE = 8'h03;
  localparam logic [7:0] ERR_PWM_PRD = 8'h04;
  typedef enum logic [2:0] {ST_IDLE, ST_RELAY, ST_DIV, ST_COEF, ST_DONE, ST_FAULT} state_t;
endpackage

// ---- rtl/atune_div.sv ----
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module atune_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [32:0] dividend,
  input wire logic [15:0] divisor,
  // answer
  output logic done,
  output logic [32:0] quotient
);
  logic [15:0] rem_r;
  logic [5:0] cnt_r;
  logic [16:0] trial;

  // next partial remainder
  assign trial = {rem_r, quotient[32]};

  // shift-subtract loop; done pulses with the last bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= 16'h0000;
      quotient <= 33'h000000000;
      cnt_r <= 6'h00;
      done <= 1'b0;
    end else if (start) begin
      rem_r <= 16'h0000;
      quotient <= dividend;
      cnt_r <= 6'h21;
      done <= 1'b0;
    end else if (cnt_r != 6'h00) begin
      if (trial >= {1'b0, divisor}) begin
        rem_r <= 16'(trial - {1'b0, divisor});
        quotient <= {quotient[31:0], 1'b1};
      end else begin
        rem_r <= trial[15:0];
        quotient <= {quotient[31:0], 1'b0};
      end
      cnt_r <= cnt_r - 6'h01;
      done <= (cnt_r == 6'h01);
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/atune_plant.sv ----
// process model: integrating plant driven by the tuner output
`timescale 1ns/1ps
`default_nettype none
module atune_plant #(
  parameter int unsigned TICK = 100
) (
  // clock
  input wire logic clk,
  // direction and drive
  input wire logic rev,
  input wire logic [15:0] mv,
  // measured value
  output logic [15:0] pv = 16'h0000
);
  int unsigned cnt = 0;
  // slow ramp so the relay sees a few compares per swing
  always_ff @(posedge clk) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    // high drive raises pv forward, lowers it reverse
    if (cnt == 0) begin
      pv <= (($signed(mv) > 16'sh07D0) ^ rev) ? pv + 16'h000A : pv - 16'h000A;
    end
  end
endmodule
`default_nettype wire

// ---- verification/relay_pid_autotuner_bench.sv ----
// self-checking bench for the relay auto-tuner
`timescale 1ns/1ps
`default_nettype none
module relay_pid_autotuner_bench;
  logic clk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, rev = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, pwm, q;
  logic [15:0] pv, mv;
  logic ack, err;
  int errors = 0, cmp_count = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  relay_pid_autotuner #(.STEP_CYCLES(4)) i_relay_pid_autotuner (.REF_CLK(clk), .RSTN(rstn),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PV_IN(pv), .MV_OUT(mv),
    .PWM_OUT(pwm), .ERR_OUT(err));
  atune_plant i_atune_plant (.clk(clk), .rev(rev), .mv(mv), .pv(pv));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // classic cycle; read data lands in q at the ack edge; only the watchdog ends a hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task regs();
    wb(1'h0, atune_pkg::OFS_CYCLE, 32'h0);
    chk(q, 32'h64);
    wb(1'h0, atune_pkg::OFS_MV_MAX, 32'h0);
    chk(q, 32'hFA0);
    wb(1'h0, atune_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h20);
    wb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'h1, atune_pkg::OFS_PWM_PT, 32'h5);
    wb(1'h1, atune_pkg::OFS_PWM_PRD, 32'h64);
    wb(1'h0, atune_pkg::OFS_PWM_PT, 32'h0);
    chk(q, 32'h5);
    chk(pwm, 32'h0);
  endtask
  // a bad setting must stop the loop at minimum output
  task fault(input logic [7:0] a, input logic [15:0] v, input logic [15:0] ok, input logic [7:0] c);
    // setting loaded before the start write
    wb(1'h1, a, {16'h0, v});
    wb(1'h1, atune_pkg::OFS_CTRL, 32'h29);
    repeat (3) @(posedge clk);
    chk(err, 1'h1);
    chk(mv, 16'h0);
    wb(1'h0, atune_pkg::OFS_STATUS, 32'h0);
    chk(q[15:8], c);
    wb(1'h1, a, {16'h0, ok});
  endtask
  task tune(input logic r, input logic [1:0] m, input real f, input real tdiv);
    int n;
    longint g, p, k, t;
    rev <= r;
    wb(1'h1, atune_pkg::OFS_CTRL, {26'h0, m, 1'h1, r, 2'h1});
    repeat (3) @(posedge clk);
    chk(mv, 16'hFA0);
    chk(err, 1'h0);
    repeat (10) @(posedge clk);
    chk(pwm, 32'h20);
    n = 0;
    do begin
      wb(1'h0, atune_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (q[1] !== 1'h1 && n < 10000);
    chk(q[1], 1'h1);
    wb(1'h0, atune_pkg::OFS_ULT_GAIN, 32'h0);
    g = q;
    wb(1'h0, atune_pkg::OFS_ULT_PERIOD, 32'h0);
    p = q;
    chk({31'h0, p > 0 && p % 100 == 0}, 32'h1);
    wb(1'h0, atune_pkg::OFS_KP, 32'h0);
    // table factor rounded to the nearest Q16 step, product truncated
    k = (g * $rtoi(f * 65536.0 + 0.5)) >> 16;
    chk(q, k[31:0]);
    wb(1'h0, atune_pkg::OFS_TI, 32'h0);
    if (tdiv > 0.0) begin
      t = q - $rtoi($itor(p) / tdiv);
      chk({31'h0, t >= -1 && t <= 1}, 32'h1);
    end else begin
      chk(q, 32'h0);
    end
    wb(1'h0, atune_pkg::OFS_TD, 32'h0);
    chk(q, m == atune_pkg::MODE_PID ? 32'(p / 8) : 32'h0);
    // idle output sits at minimum, so zero duty
    chk(pwm, 32'h0);
  endtask
  task end_of_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    regs();
    fault(atune_pkg::OFS_MV_MAX, 16'hFFF0, 16'hFA0, atune_pkg::ERR_MV_ORDER);
    fault(atune_pkg::OFS_CYCLE, 16'h63, 16'h64, atune_pkg::ERR_CYCLE);
    fault(atune_pkg::OFS_PWM_PRD, 16'h63, 16'h64, atune_pkg::ERR_PWM_PRD);
    tune(1'h0, atune_pkg::MODE_PID, 0.6, 2.0);
    tune(1'h0, atune_pkg::MODE_PI, 0.45, 1.2);
    wb(1'h1, atune_pkg::OFS_HYS, 32'hFFFF);
    wb(1'h0, atune_pkg::OFS_HYS, 32'h0);
    chk(q, 32'hFFFF);
    // nonzero band for the reverse run
    wb(1'h1, atune_pkg::OFS_HYS, 32'h28);
    tune(1'h1, atune_pkg::MODE_P, 0.5, 0.0);
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
